// ---- verilog/swl_slave.sv ----
// Slave end: decodes pulse-width bits on S1, answers by current on S2.
// Assumes the master end on the far side of swl_link_if and that the
// card's other interfaces live in other blocks with their own resets.
//
// Notes on behaviour
// - Master drives S1, slave drives S2.
// - S1 is voltage, S2 is current.
// - S1 pulse width carries clock and data.
// - S2 only while S1 high.
// - Reserved bits and bytes sent as zero.
// - Bytes go b8 first, b1 last.
// - Other interface resets never touch link.
// - Link reset or activation leaves others alone.
// - Signalling here never alters other contacts.
// - Link runs concurrently with other sessions.
// - Outside frames only zero idle bits.
// - Wakeup sequence precedes every sent frame.
`timescale 1ns/1ps
`default_nettype none

module swl_slave
  import swl_pkg::*;
#(
  parameter int THRESH_CYC = `SWL_THRESH_CYC,
  parameter int GLITCH_CYC = `SWL_GLITCH_CYC,
  parameter int DEACT_CYC = `SWL_DEACT_CYC
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Byte stream to send
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic [7:0] tx_zero_mask,
  input wire logic tx_last,
  output logic tx_ready,
  // Byte stream received
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  // Link status
  output logic link_active,
  output logic bit_err,
  // Link
  swl_link_if.slave link
);

  localparam logic [7:0] THRESH = 8'(THRESH_CYC);
  localparam logic [7:0] GLITCH = 8'(GLITCH_CYC);
  localparam logic [11:0] DEACT = 12'(DEACT_CYC);

  typedef struct packed {
    logic [2:0] s1_sy;
    logic lvl;
    logic [7:0] hi_cnt;
    logic [11:0] lo_cnt;
    logic active;
    logic err;
    swl_tx_type tx;
    swl_rx_type rx;
  } swl_slv_type;

  swl_slv_type q;
  swl_slv_type d;
  swl_tx_type t;
  logic rise;
  logic fall;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.rx.vld = 1'b0;
    d.err = 1'b0;
    d.s1_sy = {q.s1_sy[1:0], link.s1_line};
    // A level change counts once the last two stages agree
    if (q.s1_sy[2] == q.s1_sy[1])
      d.lvl = q.s1_sy[2];
    rise = d.lvl & ~q.lvl;
    fall = q.lvl & ~d.lvl;
    t = swl_tx_step(q.tx, tx_valid, tx_data, tx_zero_mask, tx_last);

    // Width of each high phase is the bit value
    if (rise)
      d.hi_cnt = 8'h00;
    else if (q.lvl && q.hi_cnt != 8'hff)
      d.hi_cnt = q.hi_cnt + 8'h01;

    // Long low phase means the master has deactivated the link
    if (q.lvl)
      d.lo_cnt = 12'h000;
    else if (q.lo_cnt != DEACT)
      d.lo_cnt = q.lo_cnt + 12'h001;

    if (rise)
    begin
      d.active = 1'b1;
      d.tx = t;
    end

    if (fall && q.active)
    begin
      if (q.hi_cnt < GLITCH)
        d.err = 1'b1;
      else
        d.rx = swl_rx_step(q.rx, q.hi_cnt >= THRESH);
    end

    if (!q.lvl && q.lo_cnt == DEACT)
    begin
      d.active = 1'b0;
      d.tx = SWL_TX_RST;
      d.rx = SWL_RX_RST;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // only the link reset
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      q <= '{3'h0, 1'b0, 8'h00, 12'h000, 1'b0, 1'b0, SWL_TX_RST, SWL_RX_RST};
    else
      q <= d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // current only while S1 high
  assign link.s2_out = q.tx.bit_o;
  assign link.s2_oe = q.lvl & q.active;
  assign tx_ready = rise & t.took;
  assign rx_valid = q.rx.vld;
  assign rx_data = q.rx.data;
  assign rx_last = q.rx.last;
  assign link_active = q.active;
  assign bit_err = q.err;

endmodule // swl_slave

`default_nettype wire

// ---- shared/swl_regs.svh ----
// Timing and framing constants of the single-wire link.
// Assumes a 200 MHz system clock on both ends.
`ifndef SWL_REGS_SVH
`define SWL_REGS_SVH

`define SWL_CLK_MHZ 200
`define SWL_BIT_NS 160
`define SWL_HI1_NS 120
`define SWL_HI0_NS 60
`define SWL_GLITCH_NS 15
`define SWL_DEACT_NS 2000
`define SWL_BIT_CYC ((`SWL_BIT_NS * `SWL_CLK_MHZ) / 1000)
`define SWL_HI1_CYC ((`SWL_HI1_NS * `SWL_CLK_MHZ) / 1000)
`define SWL_HI0_CYC ((`SWL_HI0_NS * `SWL_CLK_MHZ) / 1000)
`define SWL_THRESH_CYC ((`SWL_HI1_CYC + `SWL_HI0_CYC) / 2)
`define SWL_GLITCH_CYC ((`SWL_GLITCH_NS * `SWL_CLK_MHZ + 999) / 1000)
`define SWL_DEACT_CYC ((`SWL_DEACT_NS * `SWL_CLK_MHZ) / 1000)
`define SWL_WAKE_LEN 3'h2
`define SWL_IDLE_BIT 1'b0

`endif

// ---- shared/swl_pkg.sv ----
// Types and bit-level framers shared by both link ends.
// Assumes swl_regs.svh on the include path.
`include "swl_regs.svh"

package swl_pkg;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_WAKE = 5'b00010,
    TX_GAP = 5'b00100,
    TX_DATA = 5'b01000,
    TX_MORE = 5'b10000
  } swl_tx_state_type;

  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_DATA = 3'b010,
    RX_MORE = 3'b100
  } swl_rx_state_type;

  typedef struct packed {
    swl_tx_state_type st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic last;
    logic bit_o;
    logic took;
  } swl_tx_type;

  typedef struct packed {
    swl_rx_state_type st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic vld;
    logic [7:0] data;
    logic last;
  } swl_rx_type;

  localparam swl_tx_type SWL_TX_RST = '{TX_IDLE, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0};
  localparam swl_rx_type SWL_RX_RST = '{RX_HUNT, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0};

  // Next bit to send: wakeup ones, a zero, then bytes b8 first,
  // each byte followed by a more-bit (1 = another byte follows)
  function automatic swl_tx_type swl_tx_step(input swl_tx_type s, input logic v,
                                             input logic [7:0] d, input logic [7:0] zmask,
                                             input logic last);
    swl_tx_type n;
    n = s;
    n.took = 1'b0;
    n.bit_o = `SWL_IDLE_BIT;
    unique case (s.st)
      TX_IDLE:
        if (v)
        begin
          n.st = TX_WAKE;
          n.cnt = `SWL_WAKE_LEN - 3'h1;
          n.sh = d & ~zmask;
          n.last = last;
          n.took = 1'b1;
          n.bit_o = 1'b1;
        end
      TX_WAKE:
        if (s.cnt != 3'h0)
        begin
          n.cnt = s.cnt - 3'h1;
          n.bit_o = 1'b1;
        end
        else
          n.st = TX_GAP;
      TX_GAP, TX_MORE:
      begin
        n.st = TX_DATA;
        n.cnt = 3'h7;
        n.bit_o = s.sh[7];
        n.sh = {s.sh[6:0], 1'b0};
      end
      TX_DATA:
        if (s.cnt != 3'h0)
        begin
          n.cnt = s.cnt - 3'h1;
          n.bit_o = s.sh[7];
          n.sh = {s.sh[6:0], 1'b0};
        end
        else if (!s.last && v)
        begin
          n.st = TX_MORE;
          n.sh = d & ~zmask;
          n.last = last;
          n.took = 1'b1;
          n.bit_o = 1'b1;
        end
        else
          n.st = TX_IDLE;
      default:
        n = SWL_TX_RST;
    endcase
    return n;
  endfunction

  // Consume one received bit; a byte is presented with its more-bit
  function automatic swl_rx_type swl_rx_step(input swl_rx_type s, input logic b);
    swl_rx_type n;
    n = s;
    n.vld = 1'b0;
    unique case (s.st)
      RX_HUNT:
        if (b)
          n.cnt = (s.cnt == 3'h7) ? s.cnt : s.cnt + 3'h1;
        else if (s.cnt >= `SWL_WAKE_LEN)
        begin
          n.st = RX_DATA;
          n.cnt = 3'h0;
        end
        else
          n.cnt = 3'h0;
      RX_DATA:
      begin
        n.sh = {s.sh[6:0], b};
        n.cnt = s.cnt + 3'h1;
        if (s.cnt == 3'h7)
          n.st = RX_MORE;
      end
      RX_MORE:
      begin
        n.vld = 1'b1;
        n.data = s.sh;
        n.last = ~b;
        n.cnt = 3'h0;
        n.st = b ? RX_DATA : RX_HUNT;
      end
      default:
        n = SWL_RX_RST;
    endcase
    return n;
  endfunction

endpackage

// ---- shared/swl_link_if.sv ----
// The single wire between the two ends.
// Assumes the bench joins one master and one slave end.
`timescale 1ns/1ps
`default_nettype none

interface swl_link_if;
  logic s1_out;
  logic s1_oe;
  logic s2_out;
  logic s2_oe;
  logic s1_line;
  logic s2_line;

  // Voltage from the master; current flows only while S1 is high
  assign s1_line = s1_oe & s1_out;
  assign s2_line = s2_oe & s2_out & s1_line;

  modport master (output s1_out, output s1_oe, input s2_line);
  modport slave (input s1_line, output s2_out, output s2_oe);
endinterface

`default_nettype wire

// ---- verilog/swl_master.sv ----
// Master end: makes the bit clock, drives S1 by pulse width, reads S2.
// Assumes the slave end on the far side of swl_link_if.
`timescale 1ns/1ps
`default_nettype none

module swl_master
  import swl_pkg::*;
#(
  parameter int BIT_CYC = `SWL_BIT_CYC,
  parameter int HI1_CYC = `SWL_HI1_CYC,
  parameter int HI0_CYC = `SWL_HI0_CYC
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic link_en,
  // Byte stream to send
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // Byte stream received
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  // Link
  swl_link_if.master link
);

  localparam logic [7:0] LAST_DIV = 8'(BIT_CYC - 1);
  localparam logic [7:0] HI1 = 8'(HI1_CYC);
  localparam logic [7:0] HI0 = 8'(HI0_CYC);
  localparam logic [7:0] SAMPLE = 8'(HI0_CYC - 1);

  typedef struct packed {
    logic [7:0] div;
    logic [7:0] hi;
    logic s1;
    logic [2:0] s2_sy;
    swl_tx_type tx;
    swl_rx_type rx;
  } swl_mst_type;

  swl_mst_type q;
  swl_mst_type d;
  swl_tx_type t;
  logic bit_edge;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.rx.vld = 1'b0;
    d.s2_sy = {q.s2_sy[1:0], link.s2_line};
    bit_edge = link_en && (q.div == LAST_DIV);
    t = swl_tx_step(q.tx, tx_valid, tx_data, 8'h00, tx_last);
    if (!link_en)
    begin
      d.div = LAST_DIV;
      d.s1 = 1'b0;
    end
    else
    begin
      d.div = bit_edge ? 8'h00 : q.div + 8'h01;
      if (bit_edge)
      begin
        d.tx = t;
        d.hi = t.bit_o ? HI1 : HI0;
      end
      d.s1 = d.div < d.hi;
      if (q.s1 && q.div == SAMPLE)
        d.rx = swl_rx_step(q.rx, q.s2_sy[2] & q.s2_sy[1]);
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      q <= '{LAST_DIV, 8'h00, 1'b0, 3'h0, SWL_TX_RST, SWL_RX_RST};
    else
      q <= d;
  end

  assign link.s1_out = q.s1;
  assign link.s1_oe = 1'b1;
  assign tx_ready = bit_edge & t.took;
  assign rx_valid = q.rx.vld;
  assign rx_data = q.rx.data;
  assign rx_last = q.rx.last;

endmodule // swl_master

`default_nettype wire

// ---- dv/swl_link_asserts.sv ----
// Concurrent checks on the single wire between master and slave end.
// Assumes the bench feeds it the swl_link_if signals and system clock.
`timescale 1ns/1ps
`default_nettype none

module swl_link_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Wire
  input wire logic s1_out,
  input wire logic s1_oe,
  input wire logic s2_out,
  input wire logic s2_oe,
  input wire logic s1_line,
  input wire logic s2_line
);
  logic [5:0] hi_q;
  logic [5:0] per_q;
  logic prev_q;
  logic seen_q;
  wire logic rise_w = s1_line & ~prev_q;

  // Cycles S1 has been high, and cycles since the last rise
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hi_q <= 6'h00;
      per_q <= 6'h00;
      prev_q <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      hi_q <= s1_line ? hi_q + {5'h00, ~&hi_q} : 6'h00;
      per_q <= rise_w ? 6'h01 : per_q + {5'h00, ~&per_q};
      prev_q <= s1_line;
      seen_q <= seen_q | rise_w;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s2_released;
    ##[1:6] !s2_oe;
  endsequence

  a_s1_driven: assert property (s1_oe && s1_line == s1_out)
    else $error("S1 not driven by master");
  a_s2_no_current: assert property (!s1_line [*5] |-> !s2_oe)
    else $error("S2 still driven after S1 low");
  a_s1_hi_width: assert property ($fell(s1_line) |-> (hi_q == 6'h0c || hi_q == 6'h18))
    else $error("S1 high width wrong");
  a_s1_lo_min: assert property ($fell(s1_line) |-> !s1_line [*8])
    else $error("S1 low phase too short");
  a_bit_period: assert property (rise_w && seen_q |-> per_q == 6'h20)
    else $error("bit period wrong");
  a_s2_release: assert property ($fell(s1_line) |-> s2_released)
    else $error("S2 not released after S1 fall");
  a_s2_oe_high: assert property (seen_q && s1_line && hi_q >= 6'h08 |-> s2_oe)
    else $error("S2 not driven in S1 high");
  a_s2_bit_steady: assert property (s1_line && hi_q >= 6'h08 |-> $stable(s2_out))
    else $error("S2 bit changed in S1 high");
endmodule // swl_link_asserts

`default_nettype wire

// ---- dv/tb.sv ----
// Bench joining master and slave ends over one wire, both directions.
// Assumes the design files and swl_pkg are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic sys_clk, rst, link_en, m_tv, m_tl, m_rdy, m_rv, m_rl, s_tv, s_tl, s_rdy, s_rv, s_rl;
  logic s_act, s_err;
  logic [7:0] m_td, m_rd, s_td, s_tz, s_rd;
  logic [8:0] mq[$], sq[$];
  logic s1q[$], s2q[$];
  logic s2b;
  int hc, err_total, n_checks, n_glitch;

  swl_link_if link_i();
  swl_master swl_master_i(.sys_clk(sys_clk), .rst(rst), .link_en(link_en), .tx_valid(m_tv),
    .tx_data(m_td), .tx_last(m_tl), .tx_ready(m_rdy), .rx_valid(m_rv), .rx_data(m_rd),
    .rx_last(m_rl), .link(link_i.master));
  swl_slave #(.DEACT_CYC(80)) swl_slave_i(.sys_clk(sys_clk), .rst(rst), .tx_valid(s_tv),
    .tx_data(s_td), .tx_zero_mask(s_tz), .tx_last(s_tl), .tx_ready(s_rdy), .rx_valid(s_rv),
    .rx_data(s_rd), .rx_last(s_rl), .link_active(s_act), .bit_err(s_err),
    .link(link_i.slave));
  swl_link_asserts swl_link_asserts_i(.sys_clk(sys_clk), .rst(rst), .s1_out(link_i.s1_out),
    .s1_oe(link_i.s1_oe), .s2_out(link_i.s2_out), .s2_oe(link_i.s2_oe),
    .s1_line(link_i.s1_line), .s2_line(link_i.s2_line));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Received bytes and bits seen on the wire
  always @(posedge sys_clk)
  begin
    if (m_rv === 1'b1) mq.push_back({m_rl, m_rd});
    if (s_rv === 1'b1) sq.push_back({s_rl, s_rd});
    if (s_err === 1'b1) n_glitch++;
    if (link_i.s1_line === 1'b1)
    begin
      hc++;
      if (hc == 8) s2b = link_i.s2_line;
    end
    else if (hc != 0)
    begin
      s1q.push_back(hc >= 18);
      s2q.push_back(s2b);
      hc = 0;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, e, g);
    end
  endtask

  task automatic send_frame(input bit sl, input logic [7:0] d[$], input logic [7:0] z[$]);
    int i, w;
    for (i = 0; i < d.size(); i++)
    begin
      if (sl)
      begin
        s_tv <= 1'b1;
        s_td <= d[i];
        s_tz <= z[i];
        s_tl <= (i == d.size() - 1);
      end
      else
      begin
        m_tv <= 1'b1;
        m_td <= d[i];
        m_tl <= (i == d.size() - 1);
      end
      w = 0;
      do
      begin
        @(negedge sys_clk);
        w++;
      end
      while ((sl ? s_rdy : m_rdy) !== 1'b1 && w < 4000);
      // A byte never taken counts as a mismatch
      if ((sl ? s_rdy : m_rdy) !== 1'b1)
        err_total++;
      @(posedge sys_clk);
    end
    if (sl) s_tv <= 1'b0;
    else m_tv <= 1'b0;
  endtask

  task automatic wire_chk(input string nm, input logic q[$], input logic [7:0] d[$]);
    int i, k, n;
    logic [31:0] e, g;
    i = 0;
    while (i < q.size() && q[i] !== 1'b1) i++;
    chk({nm, "_idle"}, 32'h1, 32'(i >= 2));
    e = 32'h6;
    g = 32'h0;
    n = 3 + 9 * d.size();
    for (k = 0; k < d.size(); k++) e = {e[22:0], d[k], k != d.size() - 1};
    for (k = 0; k < n; k++) g = {g[30:0], q[i + k]};
    chk(nm, e, g);
    g = 32'h0;
    for (k = 0; k < 3; k++) g = {g[30:0], q[i + n + k]};
    chk({nm, "_tail"}, 32'h0, g);
  endtask

  task automatic run(input logic [7:0] md[$], input logic [7:0] sd[$], input logic [7:0] sz[$]);
    logic [7:0] sm[$];
    int k;
    s1q.delete();
    s2q.delete();
    mq.delete();
    sq.delete();
    repeat (100) @(posedge sys_clk);
    fork
      send_frame(1'b0, md, md);
      send_frame(1'b1, sd, sz);
    join
    repeat (600) @(posedge sys_clk);
    for (k = 0; k < sd.size(); k++) sm.push_back(sd[k] & ~sz[k]);
    chk("slave_rx_n", md.size(), sq.size());
    chk("master_rx_n", sm.size(), mq.size());
    for (k = 0; k < md.size(); k++) chk("slave_rx", 32'({k == md.size() - 1, md[k]}), 32'(sq[k]));
    for (k = 0; k < sm.size(); k++) chk("master_rx", 32'({k == sm.size() - 1, sm[k]}), 32'(mq[k]));
    wire_chk("s1_wire", s1q, md);
    wire_chk("s2_wire", s2q, sm);
    chk("link_active", 32'h1, 32'(s_act));
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_total++;
    complete_run();
  end

  initial
  begin
    rst <= 1'b1;
    link_en <= 1'b1;
    {m_tv, m_tl, s_tv, s_tl} <= 4'h0;
    {m_td, s_td, s_tz} <= 24'h000000;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    run({8'ha5, 8'h3c, 8'h81}, {8'hff, 8'h81}, {8'h0f, 8'h00});
    run({8'h00}, {8'h5a}, {8'hff});
    // Switch off only in a low phase, so no bit is cut short
    @(negedge link_i.s1_line);
    @(posedge sys_clk);
    link_en <= 1'b0;
    repeat (200) @(posedge sys_clk);
    chk("bit_err", 32'h0, 32'(n_glitch));
    chk("link_off", 32'h0, 32'(s_act));
    chk("s1_off", 32'h0, 32'(link_i.s1_line));
    complete_run();
  end
endmodule // tb

`default_nettype wire
